// [cise_defs.vh]
// Constants for the instruction-subset execute unit: encodings, register map,
// reset values and watchdog widths. Definitions only.
`ifndef CISE_DEFS_VH
`define CISE_DEFS_VH

// ----------------------------------------------------------------------------
// Instruction word layout
// ----------------------------------------------------------------------------
`define CISE_IW_W          14
`define CISE_OPC_HI        13
`define CISE_OPC_LO        11
`define CISE_BIT_HI        10
`define CISE_BIT_LO        8
`define CISE_DEST_BIT      7
`define CISE_FADDR_HI      6
`define CISE_K_HI          10

// ----------------------------------------------------------------------------
// Operation codes (instruction bits 13:11)
// ----------------------------------------------------------------------------
`define CISE_OP_OTHER      3'h0
`define CISE_OP_BTSS       3'h1
`define CISE_OP_CALL       3'h2
`define CISE_OP_COMP       3'h3
`define CISE_OP_CLEAR_FILE_INSTR       3'h4
`define CISE_OP_DECREMENT_FILE_INSTR       3'h5
`define CISE_OP_CLRA       3'h6
`define CISE_OP_WDCLR      3'h7

// ----------------------------------------------------------------------------
// Widths and reset values
// ----------------------------------------------------------------------------
`define CISE_PC_W          13
`define CISE_PC_RST        13'h0000
`define CISE_LATCH_W       5
`define CISE_LATCH_RST     5'h00
`define CISE_LU_HI         4
`define CISE_LU_LO         3
`define CISE_ACC_RST       8'h00
`define CISE_WD_PRE_W      8
`define CISE_WD_CNT_W      8
`define CISE_WD_PRE_MAX    8'hFF
`define CISE_WD_CNT_MAX    8'hFF

// ----------------------------------------------------------------------------
// Register port map (word index on reg_addr_i)
// ----------------------------------------------------------------------------
`define CISE_RA_W          4
`define CISE_REG_ACC       4'h0
`define CISE_REG_STATUS    4'h1
`define CISE_REG_LATCH     4'h2
`define CISE_REG_PC_LO     4'h3
`define CISE_REG_PC_HI     4'h4
`define CISE_REG_WD_CNT    4'h5
`define CISE_ST_ZERO       0
`define CISE_ST_EXP_N      1
`define CISE_ST_PD_N       2

`endif

// [cise_exec.v]
// Execute unit for a subset of an 8-bit core's instruction set: bit test with
// skip-if-set, watchdog clear, subroutine call, complement, file clear,
// accumulator clear and decrement. Holds accumulator, zero flag, watchdog
// status flags, program counter, upper latch and the watchdog itself.
// Assumes: instr_i belongs to the address on pc_o in the same cycle; the file
// register array reads combinationally at file_addr_o and writes on file_we_o;
// the return stack takes stack_data_o on the stack_push_o pulse.
//
// Overview of operation
// - Bit test skip-if-set with the bit at 1 discards the next instruction.
// - Bit at 0: next instruction runs normally, no extra cycle, flags unchanged.
// - Watchdog clear instruction zeroes the watchdog counter.
// - Same instruction also zeroes the watchdog prescaler.
// - Watchdog clear sets both active-low expired and power-down flags.
// - Call pushes program counter plus one onto the return stack.
// - Call loads its eleven-bit operand into program counter bits 10:0.
// - Call copies upper latch bits 4:3 into program counter bits 12:11.
// - Call takes two cycles and changes no status flag.
// - Complement inverts the file value; destination bit picks accumulator or file.
// - File clear writes zero to the file register and sets the zero flag.
// - Accumulator clear zeroes the accumulator and sets the zero flag.
// - Decrement subtracts one; destination bit picks accumulator or file.
// - Counter change or true test costs a second cycle run as no-operation.
`timescale 1ns/1ps
`include "cise_defs.vh"
`default_nettype none

module cise_exec
(
	input  wire                     sys_clk_i,
	input  wire                     rst_i,
	// Instruction fetch side
	input  wire [`CISE_IW_W-1:0]    instr_i,
	input  wire                     instr_valid_i,
	output wire [`CISE_PC_W-1:0]    pc_o,
	output wire                     instr_taken_o,
	// File register array
	output wire [6:0]               file_addr_o,
	input  wire [7:0]               file_rdata_i,
	output wire                     file_we_o,
	output wire [6:0]               file_waddr_o,
	output wire [7:0]               file_wdata_o,
	// Return stack
	output wire                     stack_push_o,
	output wire [`CISE_PC_W-1:0]    stack_data_o,
	// Core state
	output wire [7:0]               accumulator_o,
	output wire                     zero_flag_o,
	output wire                     watchdog_expired_flag_n_o,
	output wire                     power_down_flag_n_o,
	output wire                     watchdog_timeout_o,
	// Register port
	input  wire [`CISE_RA_W-1:0]    reg_addr_i,
	input  wire [7:0]               reg_wdata_i,
	input  wire                     reg_wr_i,
	input  wire                     reg_rd_i,
	output wire [7:0]               reg_rdata_o
);

	// ------------------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------------------
	function is_zero;
		input [7:0] v;
		begin
			is_zero = (v == 8'h00);
		end
	endfunction

	// ------------------------------------------------------------------------
	// State
	// ------------------------------------------------------------------------
	reg [`CISE_PC_W-1:0]    pc_reg;
	reg [`CISE_PC_W-1:0]    pc_next;
	reg [`CISE_PC_W-1:0]    resume_reg;
	reg [`CISE_PC_W-1:0]    resume_next;
	reg                     flush_reg;
	reg                     flush_next;
	reg [7:0]               acc_reg;
	reg [7:0]               acc_next;
	reg                     zero_reg;
	reg                     zero_next;
	reg                     exp_n_reg;
	reg                     exp_n_next;
	reg                     pd_n_reg;
	reg                     pd_n_next;
	reg [`CISE_LATCH_W-1:0] latch_reg;
	reg [`CISE_LATCH_W-1:0] latch_next;
	reg                     fwe_reg;
	reg                     fwe_next;
	reg [6:0]               fwaddr_reg;
	reg [6:0]               fwaddr_next;
	reg [7:0]               fwdata_reg;
	reg [7:0]               fwdata_next;
	reg                     push_reg;
	reg                     push_next;
	reg [`CISE_PC_W-1:0]    sdata_reg;
	reg [`CISE_PC_W-1:0]    sdata_next;
	reg [`CISE_WD_PRE_W-1:0] wpre_reg;
	reg [`CISE_WD_PRE_W-1:0] wpre_next;
	reg [`CISE_WD_CNT_W-1:0] wcnt_reg;
	reg [`CISE_WD_CNT_W-1:0] wcnt_next;
	reg                     wto_reg;
	reg                     wto_next;
	reg [7:0]               rdata_reg;
	reg [7:0]               rdata_next;

	// ------------------------------------------------------------------------
	// Decode
	// ------------------------------------------------------------------------
	wire [2:0]              opcode  = instr_i[`CISE_OPC_HI:`CISE_OPC_LO];
	wire [2:0]              bit_sel = instr_i[`CISE_BIT_HI:`CISE_BIT_LO];
	wire                    dest_f  = instr_i[`CISE_DEST_BIT];
	wire [6:0]              faddr   = instr_i[`CISE_FADDR_HI:0];
	wire [10:0]             k_imm   = instr_i[`CISE_K_HI:0];
	wire                    exec    = instr_valid_i & ~flush_reg;
	wire [`CISE_PC_W-1:0]   pc_inc  = pc_reg + 13'h0001;

	// File writes land one edge late; forward them so a back-to-back
	// access to the same register never sees a stale value.
	wire [7:0] operand = (fwe_reg && (fwaddr_reg == faddr)) ? fwdata_reg : file_rdata_i;
	wire [7:0] comp_res = ~operand;
	wire [7:0] dec_res  = operand - 8'h01;

	// ------------------------------------------------------------------------
	// Execute
	// ------------------------------------------------------------------------
	always @*
	begin
		pc_next     = pc_reg;
		resume_next = resume_reg;
		flush_next  = 1'b0;
		acc_next    = acc_reg;
		zero_next   = zero_reg;
		exp_n_next  = exp_n_reg;
		pd_n_next   = pd_n_reg;
		latch_next  = latch_reg;
		fwe_next    = 1'b0;
		fwaddr_next = fwaddr_reg;
		fwdata_next = fwdata_reg;
		push_next   = 1'b0;
		sdata_next  = sdata_reg;
		wto_next    = 1'b0;
		wpre_next   = wpre_reg + 8'h01;
		wcnt_next   = wcnt_reg;

		// Free-running watchdog: counter steps on each prescaler wrap
		if (wpre_reg == `CISE_WD_PRE_MAX)
		begin
			wcnt_next = wcnt_reg + 8'h01;
			if (wcnt_reg == `CISE_WD_CNT_MAX)
			begin
				wto_next   = 1'b1;
				exp_n_next = 1'b0;
			end
		end

		// Software writes; a same-cycle instruction result overrides them
		if (reg_wr_i)
		begin
			case (reg_addr_i)
				`CISE_REG_ACC:    acc_next   = reg_wdata_i;
				`CISE_REG_STATUS: zero_next  = reg_wdata_i[`CISE_ST_ZERO];
				`CISE_REG_LATCH:  latch_next = reg_wdata_i[`CISE_LATCH_W-1:0];
				default:          ;
			endcase
		end

		if (flush_reg)
		begin
			// Discarded slot: nothing executes, counter jumps on
			pc_next = resume_reg;
		end
		else if (exec)
		begin
			pc_next = pc_inc;
			case (opcode)
				`CISE_OP_BTSS:
				begin
					if (operand[bit_sel])
					begin
						flush_next  = 1'b1;
						resume_next = pc_reg + 13'h0002;
					end
					// Bit clear: plain single-cycle advance, flags untouched
				end
				`CISE_OP_CALL:
				begin
					push_next   = 1'b1;
					sdata_next  = pc_inc;
					resume_next = {latch_reg[`CISE_LU_HI:`CISE_LU_LO], k_imm};
					flush_next  = 1'b1;
				end
				`CISE_OP_COMP:
				begin
					zero_next = is_zero(comp_res);
					if (dest_f)
					begin
						fwe_next    = 1'b1;
						fwaddr_next = faddr;
						fwdata_next = comp_res;
					end
					else
					begin
						acc_next = comp_res;
					end
				end
				`CISE_OP_CLEAR_FILE_INSTR:
				begin
					fwe_next    = 1'b1;
					fwaddr_next = faddr;
					fwdata_next = 8'h00;
					zero_next   = 1'b1;
				end
				`CISE_OP_DECREMENT_FILE_INSTR:
				begin
					zero_next = is_zero(dec_res);
					if (dest_f)
					begin
						fwe_next    = 1'b1;
						fwaddr_next = faddr;
						fwdata_next = dec_res;
					end
					else
					begin
						acc_next = dec_res;
					end
				end
				`CISE_OP_CLRA:
				begin
					acc_next  = `CISE_ACC_RST;
					zero_next = 1'b1;
				end
				`CISE_OP_WDCLR:
				begin
					// Clear beats a same-cycle expiry
					wcnt_next  = 8'h00;
					wpre_next  = 8'h00;
					wto_next   = 1'b0;
					exp_n_next = 1'b1;
					pd_n_next  = 1'b1;
				end
				default:
				begin
					// Outside this subset: treated as a single-cycle no-op
				end
			endcase
		end
	end

	// ------------------------------------------------------------------------
	// Register read
	// ------------------------------------------------------------------------
	// Read data stand for one cycle and are zero otherwise, so read data of
	// several blocks may simply be ORed together
	always @*
	begin
		rdata_next = 8'h00;
		if (reg_rd_i)
		begin
			case (reg_addr_i)
				`CISE_REG_ACC:    rdata_next = acc_reg;
				`CISE_REG_STATUS: rdata_next = {5'h00, pd_n_reg, exp_n_reg, zero_reg};
				`CISE_REG_LATCH:  rdata_next = {3'h0, latch_reg};
				`CISE_REG_PC_LO:  rdata_next = pc_reg[7:0];
				`CISE_REG_PC_HI:  rdata_next = {3'h0, pc_reg[12:8]};
				`CISE_REG_WD_CNT: rdata_next = wcnt_reg;
				default:          rdata_next = 8'h00;
			endcase
		end
	end

	// ------------------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------------------
	always @(posedge sys_clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			pc_reg     <= `CISE_PC_RST;
			resume_reg <= `CISE_PC_RST;
			flush_reg  <= 1'b0;
			acc_reg    <= `CISE_ACC_RST;
			zero_reg   <= 1'b0;
			exp_n_reg  <= 1'b1;
			pd_n_reg   <= 1'b1;
			latch_reg  <= `CISE_LATCH_RST;
			fwe_reg    <= 1'b0;
			fwaddr_reg <= 7'h00;
			fwdata_reg <= 8'h00;
			push_reg   <= 1'b0;
			sdata_reg  <= `CISE_PC_RST;
			wpre_reg   <= 8'h00;
			wcnt_reg   <= 8'h00;
			wto_reg    <= 1'b0;
			rdata_reg  <= 8'h00;
		end
		else
		begin
			pc_reg     <= pc_next;
			resume_reg <= resume_next;
			flush_reg  <= flush_next;
			acc_reg    <= acc_next;
			zero_reg   <= zero_next;
			exp_n_reg  <= exp_n_next;
			pd_n_reg   <= pd_n_next;
			latch_reg  <= latch_next;
			fwe_reg    <= fwe_next;
			fwaddr_reg <= fwaddr_next;
			fwdata_reg <= fwdata_next;
			push_reg   <= push_next;
			sdata_reg  <= sdata_next;
			wpre_reg   <= wpre_next;
			wcnt_reg   <= wcnt_next;
			wto_reg    <= wto_next;
			rdata_reg  <= rdata_next;
		end
	end

	// ------------------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------------------
	assign pc_o                      = pc_reg;
	assign instr_taken_o             = exec;
	assign file_addr_o               = faddr;
	assign file_we_o                 = fwe_reg;
	assign file_waddr_o              = fwaddr_reg;
	assign file_wdata_o              = fwdata_reg;
	assign stack_push_o              = push_reg;
	assign stack_data_o              = sdata_reg;
	assign accumulator_o             = acc_reg;
	assign zero_flag_o               = zero_reg;
	assign watchdog_expired_flag_n_o = exp_n_reg;
	assign power_down_flag_n_o       = pd_n_reg;
	assign watchdog_timeout_o        = wto_reg;
	assign reg_rdata_o               = rdata_reg;

endmodule // cise_exec

`default_nettype wire

// [cise_exec_properties.sv]
// Concurrent checks for the instruction-subset execute unit.
// Sees only the unit's ports; a file read right after a write to the same
// address is forwarded inside, so those cycles are left out of data checks.
`timescale 1ns/1ps
`default_nettype none
module cise_exec_properties
(
	input wire logic        sys_clk_i,
	input wire logic        rst_i,
	input wire logic [13:0] instr_i,
	input wire logic        instr_valid_i,
	input wire logic        instr_taken_o,
	input wire logic [12:0] pc_o,
	input wire logic [7:0]  file_rdata_i,
	input wire logic        file_we_o,
	input wire logic [6:0]  file_waddr_o,
	input wire logic [7:0]  file_wdata_o,
	input wire logic        stack_push_o,
	input wire logic [12:0] stack_data_o,
	input wire logic [7:0]  accumulator_o,
	input wire logic        zero_flag_o,
	input wire logic        watchdog_expired_flag_n_o,
	input wire logic        power_down_flag_n_o,
	input wire logic        watchdog_timeout_o,
	input wire logic        reg_wr_i
);
	// ------------------------------------------------------------------
	// Helper logic
	// ------------------------------------------------------------------
	wire         ex = instr_taken_o;
	wire  [2:0]  op = instr_i[13:11];
	wire         bit_set = file_rdata_i[instr_i[10:8]];
	wire         fresh = !(file_we_o && file_waddr_o == instr_i[6:0]);
	logic [16:0] wd_age_reg;
	always @(posedge sys_clk_i or posedge rst_i)
	begin
		if (rst_i)
			wd_age_reg <= 17'h00000;
		else if ((ex && op == 3'h7) || watchdog_timeout_o)
			wd_age_reg <= 17'h00000;
		else if (wd_age_reg != 17'h1FFFF)
			wd_age_reg <= wd_age_reg + 17'h00001;
	end
	default clocking @(posedge sys_clk_i); endclocking
	default disable iff (rst_i);
	// ------------------------------------------------------------------
	// Properties
	// ------------------------------------------------------------------
	chk_skip_taken: assert property (ex && op == 3'h1 && fresh && bit_set
		|=> !instr_taken_o ##1 pc_o == $past(pc_o, 2) + 13'h0002) else $error("skip slot not flushed");
	chk_skip_plain: assert property (ex && op == 3'h1 && fresh && !bit_set && !reg_wr_i
		|=> instr_taken_o == instr_valid_i && $stable(zero_flag_o)) else $error("skip stalled");
	chk_wd_no_early: assert property (watchdog_timeout_o |-> wd_age_reg >= 17'h0FFFE)
		else $error("watchdog expired early");
	chk_wd_flags_set: assert property (ex && op == 3'h7
		|=> watchdog_expired_flag_n_o && power_down_flag_n_o) else $error("status bits not set");
	chk_call_push: assert property (ex && op == 3'h2
		|=> stack_push_o && stack_data_o == $past(pc_o) + 13'h0001) else $error("bad push");
	chk_call_target: assert property (ex && op == 3'h2
		|=> !instr_taken_o ##1 pc_o[10:0] == $past(instr_i[10:0], 2)) else $error("bad call");
	chk_clear_file: assert property (ex && op == 3'h4 |=> zero_flag_o && file_we_o
		&& file_wdata_o == 8'h00 && file_waddr_o == $past(instr_i[6:0])) else $error("bad clear");
	chk_clear_acc: assert property (ex && op == 3'h6
		|=> accumulator_o == 8'h00 && zero_flag_o) else $error("accumulator not cleared");
	chk_comp_acc: assert property (ex && op == 3'h3 && !instr_i[7] && fresh
		|=> accumulator_o == ~$past(file_rdata_i) && zero_flag_o == ($past(file_rdata_i) == 8'hFF))
		else $error("bad complement");
	chk_decrement_file_instr_file: assert property (ex && op == 3'h5 && instr_i[7] && fresh
		|=> file_we_o && file_wdata_o == $past(file_rdata_i) - 8'h01
		&& zero_flag_o == ($past(file_rdata_i) == 8'h01)) else $error("bad decrement");
	cover property (ex && op == 3'h2);
	cover property (ex && op == 3'h1 && bit_set);
	cover property (watchdog_timeout_o);
endmodule // cise_exec_properties

bind cise_exec cise_exec_properties u_cise_exec_properties (.sys_clk_i, .rst_i, .instr_i,
	.instr_valid_i, .instr_taken_o, .pc_o, .file_rdata_i, .file_we_o, .file_waddr_o,
	.file_wdata_o, .stack_push_o, .stack_data_o, .accumulator_o, .zero_flag_o,
	.watchdog_expired_flag_n_o, .power_down_flag_n_o, .watchdog_timeout_o, .reg_wr_i);
`default_nettype wire

// [test_cise_exec.sv]
// Self-checking bench for the execute unit: instructions, file memory, register port.
// Assumes file reads answer in the same cycle, so the memory here is combinational.
`timescale 1ns/1ps
`include "cise_defs.vh"
`default_nettype none
module test_cise_exec;
	logic        sys_clk_i = 1'h0;
	logic        rst_i = 1'h1;
	logic [13:0] instr_i = 14'h0000;
	logic        instr_valid_i = 1'h0;
	logic [3:0]  reg_addr_i = 4'h0;
	logic [7:0]  reg_wdata_i = 8'h00;
	logic        reg_wr_i = 1'h0;
	logic        reg_rd_i = 1'h0;
	wire  [12:0] pc_o, stack_data_o;
	wire  [7:0]  file_rdata_i, file_wdata_o, accumulator_o, reg_rdata_o;
	wire  [6:0]  file_addr_o, file_waddr_o;
	wire         instr_taken_o, file_we_o, stack_push_o, zero_flag_o;
	wire         watchdog_expired_flag_n_o, power_down_flag_n_o, watchdog_timeout_o;
	logic [7:0]  fmem [0:127];
	logic [12:0] push_val, p;
	logic [7:0]  v;
	logic        took;
	int          n_push, np, i, n_fail, checked, n_wto;
	cise_exec u_cise_exec (.sys_clk_i, .rst_i, .instr_i, .instr_valid_i, .pc_o, .instr_taken_o,
		.file_addr_o, .file_rdata_i, .file_we_o, .file_waddr_o, .file_wdata_o, .stack_push_o,
		.stack_data_o, .accumulator_o, .zero_flag_o, .watchdog_expired_flag_n_o,
		.power_down_flag_n_o, .watchdog_timeout_o, .reg_addr_i, .reg_wdata_i, .reg_wr_i,
		.reg_rd_i, .reg_rdata_o);
	always #25 sys_clk_i = ~sys_clk_i;
	assign file_rdata_i = fmem[file_addr_o];
	always @(posedge sys_clk_i)
	begin
		if (file_we_o)
			fmem[file_waddr_o] <= file_wdata_o;
		if (stack_push_o)
			push_val <= stack_data_o;
		if (stack_push_o)
			n_push <= n_push + 1;
		if (watchdog_timeout_o)
			n_wto <= n_wto + 1;
	end
	// ------------------------------------------------------------------
	// Access tasks
	// ------------------------------------------------------------------
	task chk(input logic [15:0] s, input logic [15:0] e);
		checked++;
		if (s !== e)
		begin
			n_fail++;
			$display("Error at %0t ns: seen %h expected %h", $time, s, e);
		end
	endtask
	task stop_test;
		$display("checked %0d n_fail %0d", checked, n_fail);
		if (n_fail == 0 && checked > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	// Every step launches at a rising edge and returns at the falling edge
	task step(input logic vl, input logic [13:0] iw, input logic [3:0] a, input logic [7:0] d,
		input logic w, input logic r);
		@(posedge sys_clk_i);
		instr_valid_i <= vl;
		instr_i <= iw;
		reg_addr_i <= a;
		reg_wdata_i <= d;
		reg_wr_i <= w;
		reg_rd_i <= r;
		@(negedge sys_clk_i);
		took = instr_taken_o;
	endtask
	task exe(input logic [13:0] iw);
		step(1'h1, iw, 4'h0, 8'h00, 1'h0, 1'h0);
	endtask
	task idle;
		step(1'h0, 14'h0000, 4'h0, 8'h00, 1'h0, 1'h0);
	endtask
	task wr(input logic [3:0] a, input logic [7:0] d);
		step(1'h0, 14'h0000, a, d, 1'h1, 1'h0);
	endtask
	task rd(input logic [3:0] a, output logic [7:0] d);
		step(1'h0, 14'h0000, a, 8'h00, 1'h0, 1'h1);
		idle;
		d = reg_rdata_o;
	endtask
	function automatic logic [13:0] ins(input logic [2:0] o, input logic [2:0] b,
		input logic d, input logic [6:0] f);
		ins = {o, b, d, f};
	endfunction
	task do_call(input logic [4:0] lt, input logic [10:0] k);
		wr(`CISE_REG_LATCH, {3'h0, lt});
		p = pc_o;
		np = n_push;
		exe({`CISE_OP_CALL, k});
		exe(ins(`CISE_OP_CLRA, 3'h0, 1'h0, 7'h00));
		chk(took, 1'h0);
		idle;
		chk(pc_o, {lt[4:3], k});
		chk(push_val, p + 13'h0001);
		chk(n_push, np + 1);
		chk(accumulator_o, 8'h3C);
	endtask
	// ------------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------------
	initial
	begin
		for (i = 0; i < 128; i++)
			fmem[i] = 8'h00;
		fmem[5] = 8'h5A;
		fmem[6] = 8'hFF;
		fmem[7] = 8'h01;
		fmem[8] = 8'h03;
		fmem[9] = 8'hA5;
		repeat (8) @(posedge sys_clk_i);
		rst_i <= 1'h0;
		rd(`CISE_REG_STATUS, v);
		chk(v, 8'h06);
		exe(ins(`CISE_OP_COMP, 3'h0, 1'h0, 7'h05));
		exe(ins(`CISE_OP_COMP, 3'h0, 1'h1, 7'h06));
		// File writes land one cycle after execution, so wait two cycles
		repeat (2) idle;
		chk(accumulator_o, 8'hA5);
		chk(fmem[6], 8'h00);
		chk(zero_flag_o, 1'h1);
		exe(ins(`CISE_OP_DECREMENT_FILE_INSTR, 3'h0, 1'h0, 7'h07));
		exe(ins(`CISE_OP_DECREMENT_FILE_INSTR, 3'h0, 1'h1, 7'h08));
		exe(ins(`CISE_OP_DECREMENT_FILE_INSTR, 3'h0, 1'h1, 7'h08));
		repeat (2) idle;
		chk(accumulator_o, 8'h00);
		chk(fmem[8], 8'h01);
		chk(zero_flag_o, 1'h0);
		exe(ins(`CISE_OP_CLEAR_FILE_INSTR, 3'h0, 1'h0, 7'h08));
		repeat (2) idle;
		chk(fmem[8], 8'h00);
		chk(zero_flag_o, 1'h1);
		exe(ins(`CISE_OP_COMP, 3'h0, 1'h0, 7'h08));
		exe(ins(`CISE_OP_CLRA, 3'h0, 1'h0, 7'h00));
		idle;
		chk(accumulator_o, 8'h00);
		chk(zero_flag_o, 1'h1);
		p = pc_o;
		for (i = 0; i < 8; i++)
		begin
			exe(ins(`CISE_OP_BTSS, i[2:0], 1'h0, 7'h09));
			exe(14'h0000);
			chk(took, !fmem[9][i]);
		end
		idle;
		chk(pc_o, p + 13'h0010);
		chk(zero_flag_o, 1'h1);
		exe(ins(`CISE_OP_BTSS, 3'h7, 1'h0, 7'h09));
		exe(ins(`CISE_OP_COMP, 3'h0, 1'h0, 7'h09));
		idle;
		chk(accumulator_o, 8'h00);
		wr(`CISE_REG_ACC, 8'h3C);
		do_call(5'h0F, 11'h7FF);
		do_call(5'h10, 11'h000);
		rd(`CISE_REG_PC_HI, v);
		chk(v, 8'h10);
		wr(4'hF, 8'hFF);
		rd(4'hF, v);
		chk(v, 8'h00);
		rd(`CISE_REG_ACC, v);
		chk(v, 8'h3C);
		for (i = 0; i < 70000 && watchdog_expired_flag_n_o !== 1'h0; i++)
			idle;
		if (i >= 70000)
		begin
			n_fail++;
			stop_test;
		end
		repeat (600) idle;
		exe(ins(`CISE_OP_WDCLR, 3'h0, 1'h0, 7'h00));
		idle;
		chk(watchdog_expired_flag_n_o, 1'h1);
		chk(power_down_flag_n_o, 1'h1);
		rd(`CISE_REG_WD_CNT, v);
		chk(v, 8'h00);
		repeat (200) idle;
		exe(ins(`CISE_OP_WDCLR, 3'h0, 1'h0, 7'h00));
		repeat (200) idle;
		rd(`CISE_REG_WD_CNT, v);
		chk(v, 8'h00);
		repeat (100) idle;
		rd(`CISE_REG_WD_CNT, v);
		chk(v, 8'h01);
		chk(n_wto, 1);
		stop_test;
	end
endmodule // test_cise_exec
`default_nettype wire
